// ---- bench/slr_mem_model.sv ----
// Purpose: table memory and run sink facing the renderer
// Assumes: word array indexed by byte address over two
// Notes:   slow mode stalls both answers three cycles
`timescale 1ns/1ns
module slr_mem_model (
    input  wire logic        mclk,
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    output logic [15:0]      memData,
    output logic             memAck,
    input  wire logic        drawReq,
    output logic             drawAck,
    input  wire logic        slow
);
    logic [15:0] words [0:255];
    int          waitCnt;
    logic        ready;

    assign ready = (memReq || drawReq) && waitCnt >= (slow ? 3 : 0);

    // answers move after the falling edge and hold through the sampling edge
    always @(negedge mclk) begin
        waitCnt <= ready ? 0 : waitCnt + int'(memReq || drawReq);
        memAck  <= ready && memReq;
        drawAck <= ready && drawReq;
        // released data lines flip to the inverse of their previous value every cycle
        memData <= (ready && memReq) ? words[memAddr[8:1]] : ~memData;
    end
endmodule : slr_mem_model

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the scanline run renderer
// Assumes: the table sits at word 0 of the model memory
// Notes:   expected runs come from an independent walk of the built table
`timescale 1ns/1ns
module tb;
    logic                mclk, rst, startReq, dstBit, htBit, slow, memReq, memAck, drawReq, drawAck;
    logic                htFetch, resBit, busy, donePulse, bandFault, prevBusy;
    logic [31:0]         memAddr, expAddr, memStep, lfsr, bitRng, saveCur, topAddr;
    logic [15:0]         memData, warpVal;
    logic [31:0]         curB [32];
    slr_pkg::slr_order_s order;
    slr_pkg::slr_draw_s  drawOut;
    slr_pkg::slr_draw_s  expQ [$];
    int                  errors, checks, nw, nSpec, htCnt, htExp, saveIdx;
    int                  spWord [32], spRun [32], spDisp [32], spLong [32];

    slr_scanline_run_renderer slr_scanline_run_renderer_i (.mclk(mclk), .rst(rst), .startReq(startReq),
        .order(order), .memReq(memReq), .memAddr(memAddr), .memData(memData), .memAck(memAck),
        .drawReq(drawReq), .drawOut(drawOut), .drawAck(drawAck), .htFetch(htFetch), .dstBit(dstBit),
        .htBit(htBit), .resBit(resBit), .busy(busy), .donePulse(donePulse), .bandFault(bandFault));
    slr_mem_model slr_mem_model_i (.mclk(mclk), .memReq(memReq), .memAddr(memAddr), .memData(memData),
        .memAck(memAck), .drawReq(drawReq), .drawAck(drawAck), .slow(slow));

    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nextRand

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic put(input logic [15:0] w);
        slr_mem_model_i.words[nw] = w;
        nw++;
    endtask : put

    task automatic addSpec(input int kind, input int vm, input int hm, input int run);
        logic [43:0] v;
        int          cm;
        if (kind == 0) vm &= 1;
        cm = vm * int'(warpVal) + hm;
        spWord[nSpec] = nw;
        spRun[nSpec] = run;
        spDisp[nSpec] = cm;
        spLong[nSpec] = (kind != 0);
        nSpec++;
        v = {cm[29:0], run[13:0]};
        if (kind == 0) put({1'h0, vm[0], hm[7:0], run[5:0]});
        else if (kind == 1) v = {16'h0000, vm[1:0], hm[13:0], run[11:0]};
        if (kind == 1) put({2'h2, v[27:14]});
        if (kind == 1) put({2'h2, v[13:0]});
        if (kind == 2) put({2'h3, v[43:30]});
        if (kind == 2) put(v[29:14]);
        if (kind == 2) put({2'h3, v[13:0]});
    endtask : addSpec

    task automatic plan(input logic p180, band, ht, input logic [31:0] bEnd, input int first,
                        input logic [31:0] c, output logic flt);
        int i;
        i = first;
        flt = 1'h0;
        htExp = 0;
        forever begin
            curB[i] = c;
            if (band && c >= bEnd) begin
                flt = 1'h1;
                saveIdx = i;
                saveCur = c;
                return;
            end
            htExp += ht && spLong[i];
            // banded reverse: step back over the run first, then the offset
            c = (p180 && band) ? c - spRun[i] : c + spDisp[i];
            if (spRun[i] != 0) expQ.push_back('{addr: c, len: spRun[i][13:0]});
            c = (p180 && band) ? c - spDisp[i] : c + spRun[i];
            if (i == (p180 ? 0 : nSpec - 1)) return;
            i += p180 ? -1 : 1;
        end
    endtask : plan

    task automatic runOrder(input logic p180, band, input logic [31:0] bEnd, input logic res, ht);
        logic flt;
        int   n;
        @(negedge mclk);
        expQ.delete();
        lfsr = nextRand(lfsr);
        order = '{tableAddr: p180 ? topAddr : 32'h0000_0000, initAddr: 32'h0100_0000, warp: warpVal,
                  bandEnd: bEnd, page180: p180, banded: band, halftone: ht, resume: res, boolCode: lfsr[7:0]};
        memStep = p180 ? 32'hFFFF_FFFE : 32'h0000_0002;
        expAddr = res ? spWord[saveIdx] * 2 : order.tableAddr;
        plan(p180, band, ht, bEnd, res ? saveIdx : (p180 ? nSpec - 1 : 0), res ? saveCur : order.initAddr, flt);
        htCnt = 0;
        // held past the start so the busy refusal is exercised too
        startReq = 1'h1;
        repeat (3) @(negedge mclk);
        startReq = 1'h0;
        for (n = 0; n < 4000 && donePulse !== 1'h1; n++) @(negedge mclk);
        check(donePulse, 1);
        check(bandFault, flt);
        check(busy, 0);
        check(expQ.size(), 0);
        check(htCnt, htExp);
    endtask : runOrder

    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        if (memReq && memAck) begin
            check(memAddr, expAddr);
            expAddr = expAddr + memStep;
        end
        if (drawReq && drawAck && expQ.size() == 0) check(1, 0);
        else if (drawReq && drawAck) check(drawOut, expQ.pop_front());
        if (htFetch) htCnt++;
    end

    always @(negedge mclk) begin
        if (busy && prevBusy) check(resBit, order.boolCode[{order.halftone & htBit, 1'h0, dstBit}]);
        prevBusy = busy;
        bitRng = nextRand(bitRng);
        dstBit = bitRng[3];
        htBit = bitRng[9];
    end

    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end

    initial begin
        {rst, startReq, slow} = 3'h4;
        order = '0;
        lfsr = 32'h0001_74DE;
        bitRng = 32'h0001_74DE;
        warpVal = 16'h4000;
        addSpec(0, 0, 0, 0);
        addSpec(0, 1, -5, 10);
        addSpec(1, 3, -8192, 4095);
        addSpec(2, 2, -100, 16383);
        addSpec(0, 1, 127, 63);
        addSpec(0, 1, -128, 0);
        for (int k = 0; k < 4; k++) begin
            lfsr = nextRand(lfsr);
            addSpec(k == 2, lfsr[25:24], $signed(lfsr[7:0]) | 1, lfsr[21:10] & (k == 2 ? 12'hFFF : 12'h03F));
        end
        addSpec(0, 0, 0, 0);
        topAddr = (nw - 1) * 2;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst = 1'h0;
        runOrder(1'h0, 1'h0, 32'hFFFF_FFFF, 1'h0, 1'h1);
        runOrder(1'h0, 1'h1, curB[4], 1'h0, 1'h1);
        slow = 1'h1;
        runOrder(1'h0, 1'h1, 32'hFFFF_FFFF, 1'h1, 1'h1);
        runOrder(1'h1, 1'h1, 32'hFFFF_FFFF, 1'h0, 1'h0);
        slow = 1'h0;
        runOrder(1'h1, 1'h0, 32'hFFFF_FFFF, 1'h0, 1'h1);
        tally_and_finish();
    end
endmodule : tb

// ---- verilog/slr_pkg.sv ----
// Purpose: shared constants and types of the scanline run renderer
// Assumes: pixel addresses are bit addresses, table pointers are byte addresses
// Notes:   specifier word layouts and type codes are fixed here
// Operation
// [RULE1] table builder keeps every specifier 16-bit multiple, even byte aligned
// [RULE2] 16-bit specifier: advance 0..1 line, offset +127..-128, run 0..63
// [RULE3] 32-bit specifier: advance 0..3 lines, offset +8191..-8192, run 0..4095
// [RULE4] 48-bit specifier: signed combined offset and run 0..16383
// [RULE5] format comes from type field, present at both ends of long formats
// [RULE6] vertical unsigned downward, horizontal signed, run counts drawn pixels
// [RULE7] table builder forms combined offset as vertical times warp plus horizontal
// [RULE8] table builder puts zero terminators before first and after last specifier
// [RULE9] zero terminator executes as real no-move, zero-pixel specifier
// [RULE10] 180 degree pages parse table backwards, 0 degree pages forwards
// [RULE11] order start loads current address, updated after each specifier
// [RULE12] 0 degree: after run, address points just past last pixel
// [RULE13] 180 degree: address ends where the displacements put it
// [RULE14] displacement before run on 0 degree, after run on 180 degree
// [RULE15] banded 0 degree, frame, unbanded: add offset then draw left to right
// [RULE16] banded 180: subtract run, keep, draw, then subtract offset
// [RULE17] banded: check lower band end before each specifier, fault stops transfer
// [RULE18] after fault the list continues; rerun resumes the interrupted table
// [RULE19] only lower band boundary checked, nothing checked during a run
// [RULE20] table builder avoids offsets to earlier bands and wrapping past band end
// [RULE21] transfer touches only destination and optional halftone, never source
// [RULE22] combine code source operand is replaced by zero
// [RULE23] halftone companion fetched for 32 and 48 bit specifiers only
// [RULE24] parsing ends at closing terminator after passing opening one, then done
// [RULE25] band fault shows as status readable before the list is rerun
package slr_pkg;
    localparam int AW     = 32;
    localparam int WARP_W = 16;
    localparam int LEN_W  = 14;
    localparam int OP_W   = 8;

    localparam logic [AW-1:0] WORD_STEP = 32'h0000_0002;

    // type code in bits 15:14 of the first and last word
    localparam int         ID_HI  = 15;
    localparam int         ID_LO  = 14;
    localparam logic [1:0] ID_32  = 2'h2;
    localparam logic [1:0] ID_48  = 2'h3;
    localparam int         PAY_HI = 13;

    localparam int F16_VER    = 14;
    localparam int F16_HOR_HI = 13;
    localparam int F16_HOR_LO = 6;
    localparam int F16_LEN_HI = 5;
    localparam int F32_VER_HI = 27;
    localparam int F32_VER_LO = 26;
    localparam int F32_HOR_HI = 25;
    localparam int F32_HOR_LO = 12;
    localparam int F32_LEN_HI = 11;
    localparam int F48_CMB_HI = 43;
    localparam int F48_CMB_LO = 14;
    localparam int F48_LEN_HI = 13;

    localparam logic [1:0] WORDS16 = 2'h1;
    localparam logic [1:0] WORDS32 = 2'h2;
    localparam logic [1:0] WORDS48 = 2'h3;

    typedef enum logic [1:0] {SPEC16, SPEC32, SPEC48} slr_kind_e;

    typedef struct packed {
        slr_kind_e         kind;
        logic [LEN_W-1:0]  len;
        logic [AW-1:0]     disp;
    } slr_spec_s;

    typedef struct packed {
        logic [AW-1:0]     tableAddr;
        logic [AW-1:0]     initAddr;
        logic [WARP_W-1:0] warp;
        logic [AW-1:0]     bandEnd;
        logic              page180;
        logic              banded;
        logic              halftone;
        logic              resume;
        logic [OP_W-1:0]   boolCode;
    } slr_order_s;

    typedef struct packed {
        logic [AW-1:0]     addr;
        logic [LEN_W-1:0]  len;
    } slr_draw_s;

    function automatic logic [1:0] wordsOf(input slr_kind_e k);
        return (k == SPEC48) ? WORDS48 : (k == SPEC32) ? WORDS32 : WORDS16;
    endfunction : wordsOf
endpackage : slr_pkg

// ---- verilog/slr_scanline_run_renderer.sv ----
// Purpose: scanline order engine: parse table, move address, issue runs
// Assumes: pixel combine datapath and companion table reader are outside
// Notes:   band fault resume point kept internally for the next start
`timescale 1ns/1ns
module slr_scanline_run_renderer (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic                      startReq,
    input  wire slr_pkg::slr_order_s       order,
    output logic                           memReq,
    output logic [slr_pkg::AW-1:0]         memAddr,
    input  wire logic [15:0]               memData,
    input  wire logic                      memAck,
    output logic                           drawReq,
    output slr_pkg::slr_draw_s             drawOut,
    input  wire logic                      drawAck,
    output logic                           htFetch,
    input  wire logic                      dstBit,
    input  wire logic                      htBit,
    output logic                           resBit,
    output logic                           busy,
    output logic                           donePulse,
    output logic                           bandFault
);
    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_DRAW, ST_POST} slr_state_e;

    slr_state_e               state_ff;
    slr_pkg::slr_order_s      cfg_ff;
    logic [slr_pkg::AW-1:0]   ptr_ff;
    logic [slr_pkg::AW-1:0]   specPtr_ff;
    logic [slr_pkg::AW-1:0]   curAddr_ff;
    logic [slr_pkg::AW-1:0]   resumePtr_ff;
    logic [slr_pkg::AW-1:0]   resumeAddr_ff;
    logic [15:0]              buf_ff [3];
    logic [1:0]               wordCnt_ff;
    logic [1:0]               needCnt_ff;
    logic                     first_ff;
    logic                     bandFault_ff;
    logic                     htFetch_ff;
    logic                     donePulse_ff;
    logic                     resBit_ff;
    slr_pkg::slr_draw_s       drawOut_ff;

    logic                     fetchGo;
    logic                     fetchBusy;
    logic                     fetchDone;
    logic [15:0]              fetchWord;
    slr_pkg::slr_kind_e       idKind;
    slr_pkg::slr_spec_s       spec;
    logic [1:0]               nWords;
    logic [1:0]               slot;
    logic                     revMode;
    logic                     isNull;
    logic                     faultNow;
    logic                     lastWord;

    ////////////////////////////////////////////////////////////////////////
    // table reading

    assign fetchGo = (state_ff == ST_FETCH) && !fetchBusy && !fetchDone;

    slr_word_fetch u_fetch (
        .mclk    (mclk),
        .rst     (rst),
        .go      (fetchGo),
        .addr    (ptr_ff),
        .memReq  (memReq),
        .memAddr (memAddr),
        .memData (memData),
        .memAck  (memAck),
        .busy    (fetchBusy),
        .done    (fetchDone),
        .word    (fetchWord)
    );

    slr_spec_decode u_decode (
        .idWord (fetchWord),
        .words  ({buf_ff[0], buf_ff[1], buf_ff[2]}),
        .warp   (cfg_ff.warp),
        .idKind (idKind),
        .spec   (spec)
    );

    // the first word read carries the type either way round
    assign nWords   = (wordCnt_ff == 2'h0) ? slr_pkg::wordsOf(idKind) : needCnt_ff;
    assign slot     = cfg_ff.page180 ? 2'(nWords - 2'h1 - wordCnt_ff) : wordCnt_ff; // [RULE10]
    assign lastWord = 2'(wordCnt_ff + 2'h1) == nWords;

    // only banded 180 pages run the subtractive sequence
    assign revMode  = cfg_ff.page180 && cfg_ff.banded; // [RULE15] [RULE16]
    assign isNull   = (spec.kind == slr_pkg::SPEC16) && (buf_ff[0] == 16'h0000);
    assign faultNow = cfg_ff.banded && (curAddr_ff >= cfg_ff.bandEnd); // [RULE17] [RULE19]

    always_ff @(posedge mclk) begin
        if (rst) begin
            wordCnt_ff <= '0;
            needCnt_ff <= '0;
        end else if (state_ff == ST_FETCH && fetchDone) begin
            wordCnt_ff <= lastWord ? 2'h0 : 2'(wordCnt_ff + 2'h1);
            needCnt_ff <= nWords;
        end else if (state_ff == ST_IDLE) begin
            wordCnt_ff <= '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
            buf_ff[2] <= '0;
        end else if (state_ff == ST_FETCH && fetchDone) begin
            buf_ff[slot] <= fetchWord;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            ptr_ff <= '0;
        else if (state_ff == ST_IDLE && startReq)
            ptr_ff <= order.resume ? resumePtr_ff : order.tableAddr; // [RULE18]
        else if (state_ff == ST_FETCH && fetchDone)
            ptr_ff <= cfg_ff.page180 ? ptr_ff - slr_pkg::WORD_STEP
                                     : ptr_ff + slr_pkg::WORD_STEP; // [RULE10]
    end

    always_ff @(posedge mclk) begin
        if (rst)
            specPtr_ff <= '0;
        else if (state_ff == ST_IDLE && startReq)
            specPtr_ff <= order.resume ? resumePtr_ff : order.tableAddr;
        else if (state_ff == ST_POST)
            specPtr_ff <= ptr_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing

    always_ff @(posedge mclk) begin
        if (rst)
            cfg_ff <= '0;
        else if (state_ff == ST_IDLE && startReq)
            cfg_ff <= order;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE:  if (startReq) state_ff <= ST_FETCH;
                ST_FETCH: if (fetchDone && lastWord) state_ff <= ST_EXEC;
                ST_EXEC: begin
                    if (faultNow)
                        state_ff <= ST_IDLE; // [RULE17]
                    else if (spec.len != '0)
                        state_ff <= ST_DRAW;
                    else
                        state_ff <= ST_POST; // [RULE9]
                end
                ST_DRAW:  if (drawAck) state_ff <= ST_POST;
                ST_POST:  state_ff <= (isNull && !first_ff) ? ST_IDLE : ST_FETCH; // [RULE24]
            endcase
        end
    end

    // a resumed table does not start on its opening terminator
    always_ff @(posedge mclk) begin
        if (rst)
            first_ff <= 1'b0;
        else if (state_ff == ST_IDLE && startReq)
            first_ff <= !order.resume;
        else if (state_ff == ST_POST)
            first_ff <= 1'b0; // [RULE24]
    end

    ////////////////////////////////////////////////////////////////////////
    // destination address

    always_ff @(posedge mclk) begin
        if (rst) begin
            curAddr_ff <= '0;
        end else if (state_ff == ST_IDLE && startReq) begin
            curAddr_ff <= order.resume ? resumeAddr_ff : order.initAddr; // [RULE11]
        end else if (state_ff == ST_EXEC && !faultNow) begin
            if (revMode)
                curAddr_ff <= curAddr_ff - 32'(spec.len); // [RULE16]
            else
                curAddr_ff <= curAddr_ff + spec.disp; // [RULE14] [RULE15]
        end else if (state_ff == ST_POST) begin
            if (revMode)
                curAddr_ff <= curAddr_ff - spec.disp; // [RULE13] [RULE16]
            else
                curAddr_ff <= curAddr_ff + 32'(spec.len); // [RULE12]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            drawOut_ff <= '0;
        end else if (state_ff == ST_EXEC && !faultNow) begin
            drawOut_ff.len  <= spec.len;
            drawOut_ff.addr <= revMode ? curAddr_ff - 32'(spec.len)
                                       : curAddr_ff + spec.disp; // [RULE15] [RULE16]
        end
    end

    assign drawReq = (state_ff == ST_DRAW);

    ////////////////////////////////////////////////////////////////////////
    // band fault and completion

    always_ff @(posedge mclk) begin
        if (rst) begin
            bandFault_ff  <= 1'b0;
            resumePtr_ff  <= '0;
            resumeAddr_ff <= '0;
        end else if (state_ff == ST_EXEC && faultNow) begin
            bandFault_ff  <= 1'b1; // [RULE25]
            resumePtr_ff  <= specPtr_ff; // [RULE18]
            resumeAddr_ff <= curAddr_ff;
        end else if (state_ff == ST_IDLE && startReq) begin
            bandFault_ff  <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            donePulse_ff <= 1'b0;
        else
            donePulse_ff <= (state_ff == ST_EXEC && faultNow)
                         || (state_ff == ST_POST && isNull && !first_ff); // [RULE18] [RULE24]
    end

    ////////////////////////////////////////////////////////////////////////
    // halftone and combine

    // short specifiers are halftoned without a companion entry
    always_ff @(posedge mclk) begin
        if (rst)
            htFetch_ff <= 1'b0;
        else
            htFetch_ff <= state_ff == ST_EXEC && !faultNow && cfg_ff.halftone
                       && spec.kind != slr_pkg::SPEC16; // [RULE23]
    end

    // source operand forced to zero, halftone zero when not halftoning
    always_ff @(posedge mclk) begin
        if (rst)
            resBit_ff <= 1'b0;
        else
            resBit_ff <= cfg_ff.boolCode[{cfg_ff.halftone & htBit, 1'b0, dstBit}]; // [RULE21] [RULE22]
    end

    assign htFetch   = htFetch_ff;
    assign resBit    = resBit_ff;
    assign drawOut   = drawOut_ff;
    assign busy      = (state_ff != ST_IDLE);
    assign donePulse = donePulse_ff;
    assign bandFault = bandFault_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_start_loads: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
        state_ff == ST_IDLE && startReq && !order.resume |=> curAddr_ff == $past(order.initAddr))
        else $error("start did not load initial address");

    a_null_still: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
        state_ff == ST_EXEC && isNull && !faultNow |=> curAddr_ff == $past(curAddr_ff)
        ##1 curAddr_ff == $past(curAddr_ff, 2)) else $error("terminator moved address");

    a_fwd_run_end: assert property (@(posedge mclk) disable iff (rst) // [RULE12]
        state_ff == ST_POST && !revMode && spec.len != '0
        |=> curAddr_ff == $past(drawOut_ff.addr) + 32'($past(drawOut_ff.len)))
        else $error("address not past run end");

    a_draw_at_cur: assert property (@(posedge mclk) disable iff (rst) // [RULE15]
        drawReq |-> drawOut.addr == curAddr_ff && drawOut.len != '0)
        else $error("run not drawn at current address");

    a_fault_stops: assert property (@(posedge mclk) disable iff (rst) // [RULE17]
        state_ff == ST_EXEC && faultNow |=> bandFault && donePulse && !busy && !drawReq)
        else $error("band fault did not end transfer");

    a_ht_long_only: assert property (@(posedge mclk) disable iff (rst) // [RULE23]
        $rose(htFetch) |-> $past(spec.kind) != slr_pkg::SPEC16 && cfg_ff.halftone)
        else $error("companion fetched for short specifier");

    a_source_zero: assert property (@(posedge mclk) disable iff (rst) // [RULE22]
        ##1 resBit == $past(cfg_ff.boolCode[{cfg_ff.halftone & htBit, 1'b0, dstBit}]))
        else $error("combine did not zero source");

    a_ptr_dir: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
        state_ff == ST_FETCH && fetchDone
        |=> ptr_ff == (cfg_ff.page180 ? $past(ptr_ff) - slr_pkg::WORD_STEP
                                      : $past(ptr_ff) + slr_pkg::WORD_STEP))
        else $error("table pointer stepped wrong way");

    a_kind_match: assert property (@(posedge mclk) disable iff (rst) // [RULE5]
        state_ff == ST_EXEC |-> (spec.kind == slr_pkg::SPEC48)
        == (buf_ff[0][slr_pkg::ID_HI:slr_pkg::ID_LO] == slr_pkg::ID_48))
        else $error("specifier type misread");

    a_end_done: assert property (@(posedge mclk) disable iff (rst) // [RULE24]
        state_ff == ST_POST && isNull && !first_ff |=> donePulse && !busy)
        else $error("closing terminator did not finish");
endmodule : slr_scanline_run_renderer

// ---- verilog/slr_spec_decode.sv ----
// Purpose: decode one bit string specifier into run and displacement
// Assumes: words given in table order, first word highest
// Notes:   purely combinational
`timescale 1ns/1ns
module slr_spec_decode (
    input  wire logic [15:0]                 idWord,
    input  wire logic [47:0]                 words,
    input  wire logic [slr_pkg::WARP_W-1:0]  warp,
    output slr_pkg::slr_kind_e               idKind,
    output slr_pkg::slr_spec_s               spec
);
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [27:0] f32;
    logic [43:0] f48;

    assign w0  = words[47:32];
    assign w1  = words[31:16];
    assign w2  = words[15:0];
    assign f32 = {w0[slr_pkg::PAY_HI:0], w1[slr_pkg::PAY_HI:0]};
    assign f48 = {w0[slr_pkg::PAY_HI:0], w1, w2[slr_pkg::PAY_HI:0]};

    function automatic slr_pkg::slr_kind_e kindOf(input logic [15:0] w);
        unique case (w[slr_pkg::ID_HI:slr_pkg::ID_LO])
            slr_pkg::ID_32: return slr_pkg::SPEC32;
            slr_pkg::ID_48: return slr_pkg::SPEC48;
            default:        return slr_pkg::SPEC16;
        endcase
    endfunction : kindOf

    assign idKind = kindOf(idWord); // [RULE5]

    always_comb begin
        spec.kind = kindOf(w0); // [RULE5]
        unique case (spec.kind)
            slr_pkg::SPEC16: begin // [RULE2] [RULE6]
                spec.len  = slr_pkg::LEN_W'(w0[slr_pkg::F16_LEN_HI:0]);
                spec.disp = 32'(signed'(w0[slr_pkg::F16_HOR_HI:slr_pkg::F16_HOR_LO]))
                          + (w0[slr_pkg::F16_VER] ? 32'(warp) : 32'h0000_0000);
            end
            slr_pkg::SPEC32: begin // [RULE3] [RULE6]
                spec.len  = slr_pkg::LEN_W'(f32[slr_pkg::F32_LEN_HI:0]);
                spec.disp = 32'(signed'(f32[slr_pkg::F32_HOR_HI:slr_pkg::F32_HOR_LO]))
                          + 32'(f32[slr_pkg::F32_VER_HI:slr_pkg::F32_VER_LO]) * 32'(warp);
            end
            default: begin // [RULE4]
                spec.len  = f48[slr_pkg::F48_LEN_HI:0];
                spec.disp = 32'(signed'(f48[slr_pkg::F48_CMB_HI:slr_pkg::F48_CMB_LO]));
            end
        endcase
    end
endmodule : slr_spec_decode

// ---- verilog/slr_word_fetch.sv ----
// Purpose: one 16-bit table word read with request/acknowledge
// Assumes: memory answers on mclk, any number of cycles after the request
// Notes:   memReq holds with a stable address until memAck
`timescale 1ns/1ns
module slr_word_fetch (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     go,
    input  wire logic [slr_pkg::AW-1:0]   addr,
    output logic                          memReq,
    output logic [slr_pkg::AW-1:0]        memAddr,
    input  wire logic [15:0]              memData,
    input  wire logic                     memAck,
    output logic                          busy,
    output logic                          done,
    output logic [15:0]                   word
);
    logic                    busy_ff;
    logic                    done_ff;
    logic [slr_pkg::AW-1:0]  addr_ff;
    logic [15:0]             word_ff;

    always_ff @(posedge mclk) begin
        if (rst)
            busy_ff <= 1'b0;
        else if (go && !busy_ff)
            busy_ff <= 1'b1;
        else if (memAck)
            busy_ff <= 1'b0;
    end

    always_ff @(posedge mclk) begin
        if (rst)
            addr_ff <= '0;
        else if (go && !busy_ff)
            addr_ff <= addr;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            done_ff <= 1'b0;
            word_ff <= '0;
        end else begin
            done_ff <= busy_ff && memAck;
            if (busy_ff && memAck)
                word_ff <= memData;
        end
    end

    assign memReq  = busy_ff;
    assign memAddr = addr_ff;
    assign busy    = busy_ff;
    assign done    = done_ff;
    assign word    = word_ff;

    a_word_aligned: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
        memReq |-> !memAddr[0]) else $error("table read not word aligned");

    a_req_holds: assert property (@(posedge mclk) disable iff (rst) // [RULE1]
        memReq && !memAck |=> memReq && $stable(memAddr)) else $error("read request dropped");
endmodule : slr_word_fetch
